// [core/gate_drv_pkg.sv]
// Constants, register map and timing shared by the gate driver control block.
//
// Behaviour
// - After reset every driver output is held disabled and low.
// - Outputs follow sources only after software writes one to the enable bit.
// - Each low-side output follows its source through one of four delay levels.
// - Each high-side output follows its own source with no selectable delay.
// - Fixed source routing with a small choice for low 3 and high-side outputs.
// - Low-side outputs 0, 1 and 2 form low-side protection group one.
// - Low-side output 3 alone forms low-side protection group two.
// - All three high-side outputs form high-side protection group one.
// - Event one disables low group one and/or high group one per its mask.
// - Event two disables low group two and/or absent high group two per mask.
package gate_drv_pkg;

   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int CLK_MHZ = 50;
   localparam int DLY1_NS = 50;
   localparam int DLY2_NS = 100;
   localparam int DLY3_NS = 200;
   localparam int DLY1_CYC = (DLY1_NS * CLK_MHZ + 999) / 1000;
   localparam int DLY2_CYC = (DLY2_NS * CLK_MHZ + 999) / 1000;
   localparam int DLY3_CYC = (DLY3_NS * CLK_MHZ + 999) / 1000;

   // ---------------------------------------------------------------
   // Register map, byte address = index * 4
   // ---------------------------------------------------------------
   localparam int ADDR_W = 8;
   localparam logic [2:0] IDX_CTRL = 3'h0;
   localparam logic [2:0] IDX_DELAY = 3'h1;
   localparam logic [2:0] IDX_ROUTE = 3'h2;
   localparam logic [2:0] IDX_MASK = 3'h3;
   localparam logic [2:0] IDX_STATUS = 3'h4;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Route register fields.
   localparam int RT_LS3_LSB = 0;
   localparam int RT_HS0_BIT = 2;
   localparam int RT_HS1_LSB = 3;
   localparam int RT_HS2_BIT = 5;
   localparam int RT_W = 6;

   // Mask register fields.
   localparam int MK_E1_LOW = 0;
   localparam int MK_E1_HIGH = 1;
   localparam int MK_E2_LOW = 2;
   localparam int MK_E2_HIGH = 3;

   // Status register fields.
   localparam int ST_LS_LSB = 0;
   localparam int ST_HS_LSB = 4;
   localparam int ST_E1_BIT = 7;
   localparam int ST_E2_BIT = 8;

   // Source choices for routed low-side output 3.
   typedef enum logic [1:0] {
      SRC3_A3 = 2'h0,
      SRC3_A4 = 2'h1,
      SRC3_B0 = 2'h2,
      SRC3_OFF = 2'h3
   } tri_src_t;

endpackage

// [core/delay_tap.sv]
// Clocked delay line with a two-bit selectable tap for one low-side output.
`timescale 1ns/1ps
`default_nettype none
module delay_tap (
   input wire logic aclk, // System clock.
   input wire logic aresetn, // Synchronous reset, active low.
   input wire logic src, // Source signal.
   input wire logic [1:0] sel, // Delay code.
   output logic tap // Delayed source.
);
   import gate_drv_pkg::*;

   typedef struct packed {
      logic [DLY3_CYC-1:0] sh;
   } tap_st_t;

   tap_st_t s_q;
   tap_st_t s_d;

   always_comb begin
      s_d = s_q;
      s_d.sh = {s_q.sh[DLY3_CYC-2:0], src};
   end

   // Code 00 passes the source; higher codes pick later taps.
   always_comb begin
      case (sel)
         2'h0: tap = src;
         2'h1: tap = s_q.sh[DLY1_CYC-1];
         2'h2: tap = s_q.sh[DLY2_CYC-1];
         default: tap = s_q.sh[DLY3_CYC-1];
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

endmodule
`default_nettype wire

// [core/gate_driver_control.sv]
// Gate driver control: source routing, delays, enable, fault shutdown, AXI4-Lite registers.
//
// Local design decisions: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
module gate_driver_control (
   input wire logic aclk, // System clock, 50 MHz.
   input wire logic aresetn, // Synchronous reset, active low.
   input wire logic [gate_drv_pkg::ADDR_W-1:0] s_axi_awaddr, // Write address.
   input wire logic s_axi_awvalid, // Write address valid.
   output logic s_axi_awready, // Write address ready.
   input wire logic [31:0] s_axi_wdata, // Write data.
   input wire logic [3:0] s_axi_wstrb, // Write byte strobes.
   input wire logic s_axi_wvalid, // Write data valid.
   output logic s_axi_wready, // Write data ready.
   output logic [1:0] s_axi_bresp, // Write response.
   output logic s_axi_bvalid, // Write response valid.
   input wire logic s_axi_bready, // Write response ready.
   input wire logic [gate_drv_pkg::ADDR_W-1:0] s_axi_araddr, // Read address.
   input wire logic s_axi_arvalid, // Read address valid.
   output logic s_axi_arready, // Read address ready.
   output logic [31:0] s_axi_rdata, // Read data.
   output logic [1:0] s_axi_rresp, // Read response.
   output logic s_axi_rvalid, // Read data valid.
   input wire logic s_axi_rready, // Read data ready.
   input wire logic timer_a_channel_0, // Timer A channel 0.
   input wire logic timer_a_channel_1, // Timer A channel 1.
   input wire logic timer_a_channel_2, // Timer A channel 2.
   input wire logic timer_a_channel_3, // Timer A channel 3.
   input wire logic timer_a_channel_4, // Timer A channel 4.
   input wire logic timer_a_channel_5, // Timer A channel 5.
   input wire logic timer_a_channel_6, // Timer A channel 6.
   input wire logic timer_a_channel_7, // Timer A channel 7.
   input wire logic timer_b_channel_0, // Timer B channel 0.
   input wire logic timer_c_channel_1, // Timer C channel 1.
   input wire logic timer_d_channel_0, // Timer D channel 0.
   input wire logic fault_event_one, // Protection event one, active high.
   input wire logic fault_event_two, // Protection event two, active high.
   output logic [3:0] low_side_gate_out, // Low-side driver controls.
   output logic [2:0] high_side_gate_out // High-side driver controls.
);
   import gate_drv_pkg::*;

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   typedef struct packed {
      logic en;
      logic [7:0] dly;
      logic [RT_W-1:0] route;
      logic [3:0] mask;
      logic aw_open;
      logic aw_bad;
      logic [2:0] aw_idx;
      logic w_open;
      logic [31:0] wdata;
      logic wstrb0;
      logic bvalid;
      logic [1:0] bresp;
      logic ar_open;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic [3:0] ls;
      logic [2:0] hs;
   } ctl_st_t;

   ctl_st_t s_q;
   ctl_st_t s_d;
   logic [3:0] ls_src;
   logic [3:0] ls_tap;
   logic [2:0] hs_src;
   logic [3:0] ls_kill;
   logic [2:0] hs_kill;

   function automatic logic bad_addr(input logic [ADDR_W-1:0] a);
      bad_addr = (|a[ADDR_W-1:5]) || (a[4:2] > IDX_STATUS) || (|a[1:0]);
   endfunction

   function automatic logic [31:0] read_word(input logic [2:0] idx);
      logic [31:0] v;
      v = '0;
      case (idx)
         IDX_CTRL: v[0] = s_q.en;
         IDX_DELAY: v[7:0] = s_q.dly;
         IDX_ROUTE: v[RT_W-1:0] = s_q.route;
         IDX_MASK: v[3:0] = s_q.mask;
         IDX_STATUS: begin
            v[ST_LS_LSB +: 4] = low_side_gate_out;
            v[ST_HS_LSB +: 3] = high_side_gate_out;
            v[ST_E1_BIT] = fault_event_one;
            v[ST_E2_BIT] = fault_event_two;
         end
         default: v = '0;
      endcase
      read_word = v;
   endfunction

   // ---------------------------------------------------------------
   // Source routing and delay lines
   // ---------------------------------------------------------------
   always_comb begin
      ls_src[0] = timer_a_channel_0;
      ls_src[1] = timer_a_channel_1;
      ls_src[2] = timer_a_channel_2;
      case (tri_src_t'(s_q.route[RT_LS3_LSB +: 2]))
         SRC3_A3: ls_src[3] = timer_a_channel_3;
         SRC3_A4: ls_src[3] = timer_a_channel_4;
         SRC3_B0: ls_src[3] = timer_b_channel_0;
         default: ls_src[3] = 1'b0;
      endcase
      hs_src[0] = s_q.route[RT_HS0_BIT] ? timer_b_channel_0 : timer_a_channel_4;
      case (s_q.route[RT_HS1_LSB +: 2])
         2'h0: hs_src[1] = timer_a_channel_5;
         2'h1: hs_src[1] = timer_a_channel_7;
         2'h2: hs_src[1] = timer_c_channel_1;
         default: hs_src[1] = 1'b0;
      endcase
      hs_src[2] = s_q.route[RT_HS2_BIT] ? timer_d_channel_0 : timer_a_channel_6;
   end

   for (genvar i = 0; i < 4; i++) begin : g_ls
      delay_tap u_tap (
         .aclk(aclk),
         .aresetn(aresetn),
         .src(ls_src[i]),
         .sel(s_q.dly[2*i +: 2]),
         .tap(ls_tap[i])
      );
   end

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb begin
      s_d = s_q;
      if (s_axi_awvalid && s_q.aw_open) begin
         s_d.aw_open = 1'b0;
         s_d.aw_idx = s_axi_awaddr[4:2];
         s_d.aw_bad = bad_addr(s_axi_awaddr);
      end
      if (s_axi_wvalid && s_q.w_open) begin
         s_d.w_open = 1'b0;
         s_d.wdata = s_axi_wdata;
         s_d.wstrb0 = s_axi_wstrb[0];
      end
      // Both halves held: commit once and answer.
      if (!s_q.aw_open && !s_q.w_open && !s_q.bvalid) begin
         s_d.bvalid = 1'b1;
         s_d.bresp = s_q.aw_bad ? RESP_SLVERR : RESP_OKAY;
         if (!s_q.aw_bad && s_q.wstrb0) begin
            case (s_q.aw_idx)
               IDX_CTRL: s_d.en = s_q.wdata[0];
               IDX_DELAY: s_d.dly = s_q.wdata[7:0];
               IDX_ROUTE: s_d.route = s_q.wdata[RT_W-1:0];
               IDX_MASK: s_d.mask = s_q.wdata[3:0];
               default: s_d.en = s_q.en;
            endcase
         end
      end
      if (s_q.bvalid && s_axi_bready) begin
         s_d.bvalid = 1'b0;
         s_d.aw_open = 1'b1;
         s_d.w_open = 1'b1;
      end
      if (s_axi_arvalid && s_q.ar_open) begin
         s_d.ar_open = 1'b0;
         s_d.rvalid = 1'b1;
         s_d.rdata = bad_addr(s_axi_araddr) ? '0 : read_word(s_axi_araddr[4:2]);
         s_d.rresp = bad_addr(s_axi_araddr) ? RESP_SLVERR : RESP_OKAY;
      end
      if (s_q.rvalid && s_axi_rready) begin
         s_d.rvalid = 1'b0;
         s_d.ar_open = 1'b1;
      end
      // Drivers follow their sources only while enabled.
      s_d.ls = s_q.en ? ls_tap : 4'h0;
      s_d.hs = s_q.en ? hs_src : 3'h0;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_q <= '0;
         s_q.aw_open <= 1'b1;
         s_q.w_open <= 1'b1;
         s_q.ar_open <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   // ---------------------------------------------------------------
   // Fault shutdown
   // ---------------------------------------------------------------
   // The kill path bypasses the flops so a fault turns drivers off at once,
   // not on the next clock edge; this is the one output path after a gate.
   always_comb begin
      ls_kill[2:0] = {3{fault_event_one && s_q.mask[MK_E1_LOW]}};
      ls_kill[3] = fault_event_two && s_q.mask[MK_E2_LOW];
      hs_kill = {3{fault_event_one && s_q.mask[MK_E1_HIGH]}};
   end

   assign low_side_gate_out = s_q.ls & ~ls_kill;
   assign high_side_gate_out = s_q.hs & ~hs_kill;
   assign s_axi_awready = s_q.aw_open;
   assign s_axi_wready = s_q.w_open;
   assign s_axi_bvalid = s_q.bvalid;
   assign s_axi_bresp = s_q.bresp;
   assign s_axi_arready = s_q.ar_open;
   assign s_axi_rvalid = s_q.rvalid;
   assign s_axi_rdata = s_q.rdata;
   assign s_axi_rresp = s_q.rresp;

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   localparam int LONG_LAG = DLY3_CYC + 1;
   localparam int SHORT_LAG = DLY1_CYC + 1;
   localparam int MID_LAG = DLY2_CYC + 1;

   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   reset_bus_a : assert property (@(posedge aclk) disable iff (1'b0)
      !aresetn |=> s_axi_awready && s_axi_wready && s_axi_arready && !s_axi_bvalid &&
      !s_axi_rvalid)
      else $error("bus handshake not idle after reset");

   reset_off_a : assert property (@(posedge aclk) disable iff (1'b0)
      !aresetn |=> (low_side_gate_out == 4'h0 && high_side_gate_out == 3'h0))
      else $error("driver output active just after reset");

   enable_gate_a : assert property ($past(!s_q.en) |->
      (s_q.ls == 4'h0 && s_q.hs == 3'h0))
      else $error("driver followed source while disabled");

   long_delay_a : assert property ($past(s_q.en) && $past(s_q.dly[7:6]) == 2'h3 &&
      $past(s_q.route[RT_LS3_LSB +: 2]) == 2'h0 && $past(aresetn, LONG_LAG) &&
      $past(s_q.route[RT_LS3_LSB +: 2], LONG_LAG) == 2'h0 |->
      s_q.ls[3] == $past(timer_a_channel_3, LONG_LAG))
      else $error("low-side 3 longest delay wrong");

   zero_delay_a : assert property ($past(s_q.en) && $past(s_q.dly[3:2]) == 2'h0 |->
      s_q.ls[1] == $past(timer_a_channel_1))
      else $error("low-side 1 zero delay wrong");

   high_follow_a : assert property ($past(s_q.en) && !$past(s_q.route[RT_HS2_BIT]) |->
      s_q.hs[2] == $past(timer_a_channel_6))
      else $error("high-side 2 not following its source");

   // ---------------------------------------------------------------
   // Routing, delay, fault and write response checks
   // ---------------------------------------------------------------
   // Each routed choice but low 3 from A4 or B0, high 1 from C1 and high 2 from D0 is checked on its own, so a swapped mux leg shows up.
   // The delay checks look back across the whole line, so a reset inside
   // that window would void them; the lag guard only covers its far end.

   low3_follow_a : assert property ($past(s_q.en) && $past(s_q.dly[7:6]) == 2'h0 &&
      $past(s_q.route[RT_LS3_LSB +: 2]) == 2'h0 |-> s_q.ls[3] == $past(timer_a_channel_3))
      else $error("low-side 3 not following its first source");

   low3_off_a : assert property ($past(s_q.en) && $past(s_q.dly[7:6]) == 2'h0 &&
      $past(s_q.route[RT_LS3_LSB +: 2]) == 2'h3 |-> !s_q.ls[3])
      else $error("low-side 3 active with its source switched off");

   high0_follow_a : assert property ($past(s_q.en) && !$past(s_q.route[RT_HS0_BIT]) |->
      s_q.hs[0] == $past(timer_a_channel_4))
      else $error("high-side 0 not following its first source");

   high0_alt_a : assert property ($past(s_q.en) && $past(s_q.route[RT_HS0_BIT]) |->
      s_q.hs[0] == $past(timer_b_channel_0))
      else $error("high-side 0 not following its second source");

   high1_follow_a : assert property ($past(s_q.en) &&
      $past(s_q.route[RT_HS1_LSB +: 2]) == 2'h0 |-> s_q.hs[1] == $past(timer_a_channel_5))
      else $error("high-side 1 not following its first source");

   high1_alt_a : assert property ($past(s_q.en) &&
      $past(s_q.route[RT_HS1_LSB +: 2]) == 2'h1 |-> s_q.hs[1] == $past(timer_a_channel_7))
      else $error("high-side 1 not following its second source");

   high1_off_a : assert property ($past(s_q.en) &&
      $past(s_q.route[RT_HS1_LSB +: 2]) == 2'h3 |-> !s_q.hs[1])
      else $error("high-side 1 active with its source switched off");

   short_delay_a : assert property ($past(s_q.en) && $past(s_q.dly[3:2]) == 2'h1 &&
      $past(aresetn, SHORT_LAG) |-> s_q.ls[1] == $past(timer_a_channel_1, SHORT_LAG))
      else $error("low-side 1 short delay wrong");

   mid_delay_a : assert property ($past(s_q.en) && $past(s_q.dly[5:4]) == 2'h2 &&
      $past(aresetn, MID_LAG) |-> s_q.ls[2] == $past(timer_a_channel_2, MID_LAG))
      else $error("low-side 2 middle delay wrong");

   ev2_high_free_a : assert property (fault_event_two && !fault_event_one |->
      high_side_gate_out == s_q.hs)
      else $error("event two touched the high-side group");

   ev1_low_a : assert property (fault_event_one && s_q.mask[MK_E1_LOW] |->
      low_side_gate_out[2:0] == 3'h0 && low_side_gate_out[3] == s_q.ls[3] && !ls_kill[3]
      || fault_event_two)
      else $error("event one low group not forced off");

   ev1_high_a : assert property (fault_event_one && s_q.mask[MK_E1_HIGH] |->
      high_side_gate_out == 3'h0)
      else $error("event one high group not forced off");

   ev2_low_a : assert property (fault_event_two && s_q.mask[MK_E2_LOW] |->
      !low_side_gate_out[3] && (fault_event_one || low_side_gate_out[2:0] == s_q.ls[2:0]))
      else $error("event two low group wrong");

   bresp_hold_a : assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped early");

   // ---------------------------------------------------------------
   // Register bus checks
   // ---------------------------------------------------------------
   // One write and one read at a time keeps the slave free of queues.

   rresp_hold_a : assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
      else $error("read response changed before it was taken");

   write_answer_a : assert property (!s_axi_awready && !s_axi_wready && !s_axi_bvalid |=>
      s_axi_bvalid)
      else $error("write response late");

   read_answer_a : assert property (s_axi_arvalid && s_axi_arready |=>
      s_axi_rvalid && !s_axi_arready)
      else $error("read response late");

   write_busy_a : assert property (s_axi_bvalid |->
      !s_axi_awready && !s_axi_wready)
      else $error("new write accepted before response taken");

   // ---------------------------------------------------------------
   // Coverage
   // ---------------------------------------------------------------
   cov_enable_c : cover property (!s_q.en ##1 s_q.en);
   cov_fault_c : cover property (fault_event_one && s_q.mask[MK_E1_LOW] && s_q.ls[0]);
   cov_long_c : cover property (s_q.en && s_q.dly[7:6] == 2'h3 && s_q.ls[3]);
   cov_ev2_c : cover property (fault_event_two && s_q.mask[MK_E2_LOW] && s_q.ls[3]);
   cov_route_c : cover property (s_q.en && s_q.route[RT_HS2_BIT] && s_q.hs[2]);

endmodule
`default_nettype wire

// [verification/timer_src_model.sv]
// Behavioural model of the timer channels and protection comparators feeding the block.
`timescale 1ns/1ps
`default_nettype none
module timer_src_model (
   input wire logic aclk, // System clock.
   input wire logic [10:0] chan_cmd, // Requested channel levels.
   input wire logic [1:0] fault_cmd, // Requested event levels.
   output logic [10:0] chan, // Levels of A0..A7, B0, C1, D0.
   output logic fault_one, // Protection event one.
   output logic fault_two // Protection event two.
);
   // Timer outputs move just after a clock edge, as a real timer does.
   always @(posedge aclk) begin
      chan <= chan_cmd;
   end
   // Comparators are not clocked, so a fault reaches the block mid-cycle.
   assign fault_one = fault_cmd[0];
   assign fault_two = fault_cmd[1];
endmodule
`default_nettype wire

// [verification/test_gate_driver_control.sv]
// Self-checking testbench of the gate driver control block.
`timescale 1ns/1ps
`default_nettype none
module test_gate_driver_control;
   import gate_drv_pkg::*;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [31:0] wdata = 32'h0, rdata;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp;
   logic [10:0] chan_cmd = 11'h7ff;
   logic [10:0] chan;
   logic [1:0] fault_cmd = 2'h0;
   logic fault_one, fault_two;
   logic [3:0] low_out;
   logic [2:0] high_out;
   int err_total = 0;
   int checks = 0;
   int cyc = 0;

   // ---------------------------------------------------------------
   // Clock, parts and watchdog
   // ---------------------------------------------------------------
   initial begin
      forever #10 aclk = ~aclk;
   end

   timer_src_model src_u (.aclk(aclk), .chan_cmd(chan_cmd), .fault_cmd(fault_cmd),
      .chan(chan), .fault_one(fault_one), .fault_two(fault_two));

   gate_driver_control dut_u (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .timer_a_channel_0(chan[0]), .timer_a_channel_1(chan[1]), .timer_a_channel_2(chan[2]),
      .timer_a_channel_3(chan[3]), .timer_a_channel_4(chan[4]), .timer_a_channel_5(chan[5]),
      .timer_a_channel_6(chan[6]), .timer_a_channel_7(chan[7]), .timer_b_channel_0(chan[8]),
      .timer_c_channel_1(chan[9]), .timer_d_channel_0(chan[10]),
      .fault_event_one(fault_one), .fault_event_two(fault_two),
      .low_side_gate_out(low_out), .high_side_gate_out(high_out));

   // The whole run needs well under a thousand cycles; this only cuts a hang short.
   always @(posedge aclk) begin
      cyc++;
      if (cyc == 5000) begin
         err_total++;
         print_verdict;
      end
   end

   // ---------------------------------------------------------------
   // Shared tasks
   // ---------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      int n;
      n = 0;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         n++;
      end while (bvalid !== 1'b1 && n < 40);
      if (bvalid !== 1'b1) chk(32'(bvalid), 32'h1);
      r = bresp;
      bready <= 1'b0;
      @(posedge aclk);
   endtask

   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      int n;
      n = 0;
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
         n++;
      end while (rvalid !== 1'b1 && n < 40);
      if (rvalid !== 1'b1) chk(32'(rvalid), 32'h1);
      r = rresp;
      d = rdata;
      rready <= 1'b0;
      @(posedge aclk);
   endtask

   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic t_reset;
      logic [1:0] r;
      chk(32'({high_out, low_out}), 32'h0);
      aresetn <= 1'b1;
      repeat (4) @(posedge aclk);
      chk(32'({high_out, low_out}), 32'h0);
      axi_wr(8'h00, 32'h1, r);
      chk(32'(r), 32'(RESP_OKAY));
      repeat (3) @(posedge aclk);
      chk(32'({high_out, low_out}), 32'h7f);
   endtask

   task automatic t_route;
      logic [5:0] rt [10] = '{6'h00, 6'h01, 6'h02, 6'h04, 6'h08, 6'h10, 6'h20, 6'h00, 6'h00,
         6'h1b};
      logic [10:0] ch [10] = '{11'h008, 11'h010, 11'h100, 11'h100, 11'h080, 11'h200, 11'h400,
         11'h060, 11'h007, 11'h2b8};
      logic [6:0] ex [10] = '{7'h08, 7'h18, 7'h08, 7'h10, 7'h20, 7'h20, 7'h40, 7'h60, 7'h07,
         7'h10};
      logic [1:0] r;
      for (int i = 0; i < 10; i++) begin
         axi_wr(8'h08, {26'h0, rt[i]}, r);
         chan_cmd <= ch[i];
         repeat (3) @(posedge aclk);
         chk(32'({high_out, low_out}), 32'(ex[i]));
      end
   endtask

   // Each lane gets its own code, so field placement is checked as well as the delay.
   task automatic t_delay;
      int ext [4] = '{0, DLY1_CYC, DLY2_CYC, DLY3_CYC};
      logic [1:0] r;
      int n;
      axi_wr(8'h08, 32'h0, r);
      for (int c = 0; c < 4; c++) begin
         axi_wr(8'h04, 32'(c) << (2 * c), r);
         chan_cmd <= 11'h000;
         repeat (14) @(posedge aclk);
         chan_cmd <= 11'h001 << c;
         n = 0;
         do begin
            @(posedge aclk);
            n++;
         end while (low_out[c] !== 1'b1 && n < 30);
         chk(32'(n), 32'(3 + ext[c]));
      end
   endtask

   // A registered kill would only show one edge later than the sample taken here.
   task automatic t_fault;
      logic [1:0] r;
      logic [3:0] lo;
      logic [2:0] hi;
      axi_wr(8'h04, 32'h0, r);
      chan_cmd <= 11'h7ff;
      for (int m = 0; m < 16; m++) begin
         axi_wr(8'h0c, 32'(m), r);
         for (int e = 1; e < 4; e++) begin
            lo = 4'hf;
            hi = 3'h7;
            if (e[0] && m[0]) lo[2:0] = 3'h0;
            if (e[1] && m[2]) lo[3] = 1'b0;
            if (e[0] && m[1]) hi = 3'h0;
            fault_cmd <= e[1:0];
            @(posedge aclk);
            chk(32'({high_out, low_out}), 32'({hi, lo}));
            fault_cmd <= 2'h0;
            @(posedge aclk);
            chk(32'({high_out, low_out}), 32'h7f);
         end
      end
   endtask

   task automatic t_regs;
      logic [31:0] d;
      logic [1:0] r;
      axi_rd(8'h0c, d, r);
      chk(d, 32'hf);
      chk(32'(r), 32'(RESP_OKAY));
      axi_rd(8'h10, d, r);
      chk(d, 32'h7f);
      axi_rd(8'h14, d, r);
      chk(32'(r), 32'(RESP_SLVERR));
      axi_wr(8'h40, 32'h1, r);
      chk(32'(r), 32'(RESP_SLVERR));
      axi_wr(8'h00, 32'h0, r);
      repeat (3) @(posedge aclk);
      chk(32'({high_out, low_out}), 32'h0);
   endtask

   // A second reset while the drivers run must drop them and clear the enable.
   task automatic t_rereset;
      logic [31:0] d;
      logic [1:0] r;
      axi_wr(8'h00, 32'h1, r);
      repeat (3) @(posedge aclk);
      chk(32'({high_out, low_out}), 32'h7f);
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      chk(32'({high_out, low_out}), 32'h0);
      aresetn <= 1'b1;
      @(posedge aclk);
      axi_rd(8'h00, d, r);
      chk(d, 32'h0);
      repeat (2) @(posedge aclk);
      chk(32'({high_out, low_out}), 32'h0);
   endtask

   task automatic print_verdict;
      $display("checks=%0d err_total=%0d", checks, err_total);
      if (err_total == 0 && checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   initial begin
      repeat (5) @(posedge aclk);
      t_reset;
      t_route;
      t_delay;
      t_fault;
      t_regs;
      t_rereset;
      print_verdict;
   end
endmodule
`default_nettype wire
